// *** include/pfer_pkg.sv ***
package pfer_pkg;

	// Widths
	localparam int unsigned PFER_IO_W = 16;
	localparam int unsigned PFER_AW   = 12;

	// Register byte offsets
	localparam logic [11:0] PFER_OFS_FIN_EN   = 12'h000;
	localparam logic [11:0] PFER_OFS_FOUT_EN  = 12'h004;
	localparam logic [11:0] PFER_OFS_FIN_VAL  = 12'h008;
	localparam logic [11:0] PFER_OFS_FOUT_VAL = 12'h00c;
	localparam logic [11:0] PFER_OFS_CTRL     = 12'h010;
	localparam logic [11:0] PFER_OFS_LOG_POS  = 12'h014;
	localparam logic [11:0] PFER_OFS_CLK_YM   = 12'h018;
	localparam logic [11:0] PFER_OFS_CLK_DH   = 12'h01c;
	localparam logic [11:0] PFER_OFS_CLK_MS   = 12'h020;
	localparam logic [11:0] PFER_OFS_CLK_YW   = 12'h024;
	localparam logic [11:0] PFER_OFS_STATUS   = 12'h028;
	localparam logic [11:0] PFER_OFS_SET_YM   = 12'h030;
	localparam logic [11:0] PFER_OFS_SET_DH   = 12'h034;
	localparam logic [11:0] PFER_OFS_SET_MS   = 12'h038;
	localparam logic [11:0] PFER_OFS_SET_YW   = 12'h03c;
	localparam logic [11:0] PFER_OFS_SET_LOAD = 12'h040;
	localparam logic [3:0]  PFER_LOG_PAGE     = 4'h1;

	// Control and status bit positions
	localparam int unsigned PFER_CTRL_GLOBAL   = 0;
	localparam int unsigned PFER_CTRL_CLR_EN   = 1;
	localparam int unsigned PFER_CTRL_CLR_DATA = 2;
	localparam int unsigned PFER_CTRL_CLR_LOG  = 3;
	localparam int unsigned PFER_STAT_RUN      = 0;
	localparam int unsigned PFER_STAT_FAULT    = 1;

	// Log geometry and reset values
	localparam logic [4:0]  PFER_LOG_ENTRIES = 5'h10;
	localparam logic [4:0]  PFER_LOG_POS_RST = 5'h00;
	localparam logic [15:0] PFER_FORCE_RST   = 16'h0000;
	localparam logic [7:0]  PFER_WEEKDAY_MAX = 8'h06;

	// AXI responses
	localparam logic [1:0] PFER_RESP_OKAY   = 2'b00;
	localparam logic [1:0] PFER_RESP_SLVERR = 2'b10;

	// Calendar time, BCD fields
	typedef struct packed {
		logic [7:0] year_hi;
		logic [7:0] year_lo;
		logic [7:0] month;
		logic [7:0] day;
		logic [7:0] hour;
		logic [7:0] minute;
		logic [7:0] second;
		logic [7:0] weekday;
	} pfer_time_t;

	// Program-visible clock words
	typedef struct packed {
		logic [15:0] year_lo_month;
		logic [15:0] day_hour;
		logic [15:0] minute_second;
		logic [15:0] year_hi_weekday;
	} pfer_clk_words_t;

	// Clock states, Gray along stop, run, fault
	typedef enum logic [1:0] {
		PFER_RTC_STOP  = 2'b00,
		PFER_RTC_RUN   = 2'b01,
		PFER_RTC_FAULT = 2'b11
	} pfer_rtc_state_t;

endpackage

// *** hdl/pfer_top.sv ***
`timescale 1ns/100ps
// Operation
// - Input refresh overlays forced data on enabled bits before updating the input image.
// - Output refresh drives enabled outputs from forced data, others from output image.
// - Forcing never alters the stored output image; it does alter the input image.
// - Input force enable word and forced data word, one bit per input.
// - Output force enable word and forced data word, one bit per output.
// - A global flag gates all forcing, effective from the next refresh.
// - Force settings survive power cycle, mode change and reset switch.
// - Stop mode does not clear force settings.
// - Direct refresh moves addressed inputs or outputs immediately.
// - An error halt logs its time and error code.
// - The log keeps the latest 16 entries of four consecutive words.
// - A seventeenth error overwrites the oldest entry, circularly.
// - Header holds current entry position; words pack year/month, date/hour, min/sec, code.
// - The clock keeps counting from backup storage without main power.
// - Every scan copies the live time into the program-visible clock words.
// - Clock words in BCD: year low/month, day/hour, minute/second.
// - Fourth word holds year high digits and weekday, Sunday zero to Saturday six.
// - An out-of-range time field stops the clock.
// - Writing valid new time clears the fault and restarts the clock.
// - All-outputs-off overrides forcing; outputs stay off while it is active.
module pfer_top (
	// Clock, resets, enable
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        cold_resetn,
	input  wire logic        clk_en,
	// AXI4-Lite slave
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Scan sequencer
	input  wire logic        input_refresh,
	input  wire logic        output_refresh,
	input  wire logic        scan_start,
	input  wire logic        direct_refresh_in,
	input  wire logic        direct_refresh_out,
	input  wire logic [15:0] direct_refresh_mask,
	input  wire logic        all_outputs_off_instruction,
	input  wire logic [15:0] output_image,
	input  wire logic        error_halt,
	input  wire logic [15:0] error_code,
	output logic [15:0]      input_image,
	// Terminals and backup oscillator
	input  wire logic [15:0] in_pins,
	input  wire logic        sec_tick,
	output logic [15:0]      out_pins,
	output logic             rtc_running
);

	// Force overlay on one word
	function automatic logic [15:0] apply_force(input logic [15:0] src, input logic [15:0] en,
		input logic [15:0] val, input logic glb);
		apply_force = glb ? ((src & ~en) | (val & en)) : src;
	endfunction

	// Merge of low byte lanes into a 16-bit register
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d, input logic [3:0] s);
		merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
	endfunction

	// BCD increment of two digits
	function automatic logic [7:0] bcd_inc(input logic [7:0] v);
		bcd_inc = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
	endfunction

	// Two BCD digits, each legal, not above a limit
	function automatic logic bcd_ok(input logic [7:0] v, input logic [7:0] lim);
		bcd_ok = (v[7:4] <= 4'h9) && (v[3:0] <= 4'h9) && (v <= lim);
	endfunction

	// Last day of a month
	function automatic logic [7:0] month_days(input logic [7:0] mo, input logic [7:0] yl);
		logic leap;
		leap = yl[4] ? (yl[3:0] == 4'h2 || yl[3:0] == 4'h6)
			: (yl[3:0] == 4'h0 || yl[3:0] == 4'h4 || yl[3:0] == 4'h8);
		case (mo)
			8'h02:                      month_days = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_days = 8'h30;
			default:                    month_days = 8'h31;
		endcase
	endfunction

	// Whole-time range check
	function automatic logic time_ok(input pfer_pkg::pfer_time_t t);
		time_ok = bcd_ok(t.year_hi, 8'h99) && bcd_ok(t.year_lo, 8'h99)
			&& bcd_ok(t.month, 8'h12) && (t.month != 8'h00)
			&& bcd_ok(t.day, month_days(t.month, t.year_lo)) && (t.day != 8'h00)
			&& bcd_ok(t.hour, 8'h23) && bcd_ok(t.minute, 8'h59) && bcd_ok(t.second, 8'h59)
			&& (t.weekday <= pfer_pkg::PFER_WEEKDAY_MAX);
	endfunction

	// Retained force settings and control
	logic [15:0]                 fin_en_q;
	logic [15:0]                 fout_en_q;
	logic [15:0]                 fin_val_q;
	logic [15:0]                 fout_val_q;
	logic                        force_global_flag_q;
	// Bus slave state
	logic                        aw_hold_q;
	logic                        w_hold_q;
	logic [11:0]                 aw_addr_q;
	logic [31:0]                 w_data_q;
	logic [3:0]                  w_strb_q;
	logic                        wr_go;
	logic                        wr_ok;
	logic [31:0]                 rd_val;
	logic                        rd_ok;
	// Pin synchronisers
	logic [15:0]                 pin_s1_q;
	logic [15:0]                 pin_s2_q;
	logic [1:0]                  tick_s_q;
	logic                        tick_prev_q;
	logic                        tick_rise;
	// Clock state
	pfer_pkg::pfer_time_t        time_q;
	pfer_pkg::pfer_time_t        set_q;
	pfer_pkg::pfer_rtc_state_t   rtc_state_q;
	pfer_pkg::pfer_clk_words_t   live_words;
	pfer_pkg::pfer_clk_words_t   clk_words_q;
	logic                        set_load;
	// Error log
	logic [4:0]                  log_pos_q;
	logic [3:0]                  log_slot;
	logic [15:0]                 log_mem [0:63];
	// Overlay results
	logic [15:0]                 fin_over;
	logic [15:0]                 fout_over;

	// Bus handshakes and decoded strobes
	assign s_axi_awready = clk_en & ~aw_hold_q & ~s_axi_bvalid;
	assign s_axi_wready  = clk_en & ~w_hold_q & ~s_axi_bvalid;
	assign wr_go         = clk_en & aw_hold_q & w_hold_q & ~s_axi_bvalid;
	assign s_axi_arready = clk_en & ~s_axi_rvalid;
	assign set_load      = wr_go && aw_addr_q == pfer_pkg::PFER_OFS_SET_LOAD && w_data_q[0];
	assign tick_rise     = tick_s_q[1] & ~tick_prev_q;
	assign rtc_running   = (rtc_state_q == pfer_pkg::PFER_RTC_RUN);
	assign log_slot      = log_pos_q[3:0];

	// Writable addresses
	always_comb
	begin
		case (aw_addr_q)
			pfer_pkg::PFER_OFS_FIN_EN, pfer_pkg::PFER_OFS_FOUT_EN, pfer_pkg::PFER_OFS_FIN_VAL,
			pfer_pkg::PFER_OFS_FOUT_VAL, pfer_pkg::PFER_OFS_CTRL, pfer_pkg::PFER_OFS_SET_YM,
			pfer_pkg::PFER_OFS_SET_DH, pfer_pkg::PFER_OFS_SET_MS, pfer_pkg::PFER_OFS_SET_YW,
			pfer_pkg::PFER_OFS_SET_LOAD: wr_ok = 1'b1;
			default:                     wr_ok = 1'b0;
		endcase
	end

	// Address and data capture, either order
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_hold_q <= 1'b0;
			w_hold_q  <= 1'b0;
			aw_addr_q <= 12'h000;
			w_data_q  <= 32'h0000_0000;
			w_strb_q  <= 4'h0;
		end
		else if (clk_en)
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_hold_q <= 1'b1;
				aw_addr_q <= {s_axi_awaddr[11:2], 2'b00};
			end
			else if (wr_go)
				aw_hold_q <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_hold_q <= 1'b1;
				w_data_q <= s_axi_wdata;
				w_strb_q <= s_axi_wstrb;
			end
			else if (wr_go)
				w_hold_q <= 1'b0;
		end
	end

	// Write response
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= pfer_pkg::PFER_RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (wr_go)
			begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_ok ? pfer_pkg::PFER_RESP_OKAY : pfer_pkg::PFER_RESP_SLVERR;
			end
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// Force settings, cleared only by a cold start or the control clear bits
	always_ff @(posedge aclk)
	begin
		if (!cold_resetn)
		begin
			fin_en_q            <= pfer_pkg::PFER_FORCE_RST;
			fout_en_q           <= pfer_pkg::PFER_FORCE_RST;
			fin_val_q           <= pfer_pkg::PFER_FORCE_RST;
			fout_val_q          <= pfer_pkg::PFER_FORCE_RST;
			force_global_flag_q <= 1'b0;
		end
		else if (wr_go)
		begin
			case (aw_addr_q)
				pfer_pkg::PFER_OFS_FIN_EN:   fin_en_q   <= merge16(fin_en_q, w_data_q, w_strb_q);
				pfer_pkg::PFER_OFS_FOUT_EN:  fout_en_q  <= merge16(fout_en_q, w_data_q, w_strb_q);
				pfer_pkg::PFER_OFS_FIN_VAL:  fin_val_q  <= merge16(fin_val_q, w_data_q, w_strb_q);
				pfer_pkg::PFER_OFS_FOUT_VAL: fout_val_q <= merge16(fout_val_q, w_data_q, w_strb_q);
				pfer_pkg::PFER_OFS_CTRL:
				begin
					if (w_strb_q[0])
					begin
						force_global_flag_q <= w_data_q[pfer_pkg::PFER_CTRL_GLOBAL];
						if (w_data_q[pfer_pkg::PFER_CTRL_CLR_EN])
						begin
							fin_en_q  <= pfer_pkg::PFER_FORCE_RST;
							fout_en_q <= pfer_pkg::PFER_FORCE_RST;
						end
						if (w_data_q[pfer_pkg::PFER_CTRL_CLR_DATA])
						begin
							fin_val_q  <= pfer_pkg::PFER_FORCE_RST;
							fout_val_q <= pfer_pkg::PFER_FORCE_RST;
						end
					end
				end
				default: ;
			endcase
		end
	end

	// Terminal input and tick synchronisers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			pin_s1_q    <= 16'h0000;
			pin_s2_q    <= 16'h0000;
			tick_s_q    <= 2'b00;
			tick_prev_q <= 1'b0;
		end
		else if (clk_en)
		begin
			pin_s1_q    <= in_pins;
			pin_s2_q    <= pin_s1_q;
			tick_s_q    <= {tick_s_q[0], sec_tick};
			tick_prev_q <= tick_s_q[1];
		end
	end

	// Overlays, output image itself is never written here
	assign fin_over  = apply_force(pin_s2_q, fin_en_q, fin_val_q, force_global_flag_q);
	assign fout_over = apply_force(output_image, fout_en_q, fout_val_q, force_global_flag_q);

	// Input image update
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			input_image <= 16'h0000;
		else if (clk_en)
		begin
			if (input_refresh)
				input_image <= fin_over;
			else if (direct_refresh_in)
				input_image <= (input_image & ~direct_refresh_mask) | (fin_over & direct_refresh_mask);
		end
	end

	// Output relay drive
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			out_pins <= 16'h0000;
		else if (clk_en)
		begin
			if (all_outputs_off_instruction)
				out_pins <= 16'h0000;
			else if (output_refresh)
				out_pins <= fout_over;
			else if (direct_refresh_out)
				out_pins <= (out_pins & ~direct_refresh_mask) | (fout_over & direct_refresh_mask);
		end
	end

	// Clock set staging, kept on backup
	always_ff @(posedge aclk)
	begin
		if (!cold_resetn)
			set_q <= '0;
		else if (wr_go)
		begin
			case (aw_addr_q)
				pfer_pkg::PFER_OFS_SET_YM: {set_q.year_lo, set_q.month} <= merge16({set_q.year_lo, set_q.month},
					w_data_q, w_strb_q);
				pfer_pkg::PFER_OFS_SET_DH: {set_q.day, set_q.hour} <= merge16({set_q.day, set_q.hour},
					w_data_q, w_strb_q);
				pfer_pkg::PFER_OFS_SET_MS: {set_q.minute, set_q.second} <= merge16({set_q.minute, set_q.second},
					w_data_q, w_strb_q);
				pfer_pkg::PFER_OFS_SET_YW: {set_q.year_hi, set_q.weekday} <= merge16({set_q.year_hi, set_q.weekday},
					w_data_q, w_strb_q);
				default: ;
			endcase
		end
	end

	// Calendar counter, backup domain reset only
	always_ff @(posedge aclk)
	begin
		if (!cold_resetn)
		begin
			time_q      <= '0;
			rtc_state_q <= pfer_pkg::PFER_RTC_STOP;
		end
		else if (set_load)
		begin
			time_q      <= set_q;
			rtc_state_q <= time_ok(set_q) ? pfer_pkg::PFER_RTC_RUN : pfer_pkg::PFER_RTC_FAULT;
		end
		else if (clk_en && tick_rise)
		begin
			case (rtc_state_q)
				pfer_pkg::PFER_RTC_RUN:
				begin
					time_q.second <= bcd_inc(time_q.second);
					if (time_q.second == 8'h59)
					begin
						time_q.second <= 8'h00;
						time_q.minute <= bcd_inc(time_q.minute);
						if (time_q.minute == 8'h59)
						begin
							time_q.minute <= 8'h00;
							time_q.hour   <= bcd_inc(time_q.hour);
							if (time_q.hour == 8'h23)
							begin
								time_q.hour    <= 8'h00;
								time_q.weekday <= (time_q.weekday == pfer_pkg::PFER_WEEKDAY_MAX) ? 8'h00
									: bcd_inc(time_q.weekday);
								time_q.day     <= bcd_inc(time_q.day);
								if (time_q.day == month_days(time_q.month, time_q.year_lo))
								begin
									time_q.day   <= 8'h01;
									time_q.month <= bcd_inc(time_q.month);
									if (time_q.month == 8'h12)
									begin
										time_q.month   <= 8'h01;
										time_q.year_lo <= bcd_inc(time_q.year_lo);
										if (time_q.year_lo == 8'h99)
										begin
											time_q.year_lo <= 8'h00;
											time_q.year_hi <= bcd_inc(time_q.year_hi);
										end
									end
								end
							end
						end
					end
				end
				pfer_pkg::PFER_RTC_STOP, pfer_pkg::PFER_RTC_FAULT: ;
				default: rtc_state_q <= pfer_pkg::PFER_RTC_STOP;
			endcase
		end
	end

	// Clock words from live time
	assign live_words = '{year_lo_month:   {time_q.year_lo, time_q.month},
		day_hour:        {time_q.day, time_q.hour},
		minute_second:   {time_q.minute, time_q.second},
		year_hi_weekday: {time_q.year_hi, time_q.weekday}};

	// Per-scan copy to program words
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			clk_words_q <= '0;
		else if (clk_en && scan_start)
			clk_words_q <= live_words;
	end

	// Log position, error write wins over clear
	always_ff @(posedge aclk)
	begin
		if (!cold_resetn)
			log_pos_q <= pfer_pkg::PFER_LOG_POS_RST;
		else if (clk_en && error_halt)
			log_pos_q <= {1'b0, log_slot} + 5'h01;
		else if (wr_go && aw_addr_q == pfer_pkg::PFER_OFS_CTRL && w_strb_q[0]
			&& w_data_q[pfer_pkg::PFER_CTRL_CLR_LOG])
			log_pos_q <= pfer_pkg::PFER_LOG_POS_RST;
	end

	// Log entry words, four per slot
	always_ff @(posedge aclk)
	begin
		if (clk_en && error_halt)
		begin
			log_mem[{log_slot, 2'b00}] <= live_words.year_lo_month;
			log_mem[{log_slot, 2'b01}] <= live_words.day_hour;
			log_mem[{log_slot, 2'b10}] <= live_words.minute_second;
			log_mem[{log_slot, 2'b11}] <= error_code;
		end
	end

	// Read decode
	always_comb
	begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		if (s_axi_araddr[11:8] == pfer_pkg::PFER_LOG_PAGE)
			rd_val = {16'h0000, log_mem[s_axi_araddr[7:2]]};
		else
		begin
			case ({s_axi_araddr[11:2], 2'b00})
				pfer_pkg::PFER_OFS_FIN_EN:   rd_val = {16'h0000, fin_en_q};
				pfer_pkg::PFER_OFS_FOUT_EN:  rd_val = {16'h0000, fout_en_q};
				pfer_pkg::PFER_OFS_FIN_VAL:  rd_val = {16'h0000, fin_val_q};
				pfer_pkg::PFER_OFS_FOUT_VAL: rd_val = {16'h0000, fout_val_q};
				pfer_pkg::PFER_OFS_CTRL:     rd_val = {31'h0000_0000, force_global_flag_q};
				pfer_pkg::PFER_OFS_LOG_POS:  rd_val = {27'h000_0000, log_pos_q};
				pfer_pkg::PFER_OFS_CLK_YM:   rd_val = {16'h0000, clk_words_q.year_lo_month};
				pfer_pkg::PFER_OFS_CLK_DH:   rd_val = {16'h0000, clk_words_q.day_hour};
				pfer_pkg::PFER_OFS_CLK_MS:   rd_val = {16'h0000, clk_words_q.minute_second};
				pfer_pkg::PFER_OFS_CLK_YW:   rd_val = {16'h0000, clk_words_q.year_hi_weekday};
				pfer_pkg::PFER_OFS_STATUS:   rd_val = {30'h0000_0000, rtc_state_q == pfer_pkg::PFER_RTC_FAULT,
					rtc_running};
				pfer_pkg::PFER_OFS_SET_YM:   rd_val = {16'h0000, set_q.year_lo, set_q.month};
				pfer_pkg::PFER_OFS_SET_DH:   rd_val = {16'h0000, set_q.day, set_q.hour};
				pfer_pkg::PFER_OFS_SET_MS:   rd_val = {16'h0000, set_q.minute, set_q.second};
				pfer_pkg::PFER_OFS_SET_YW:   rd_val = {16'h0000, set_q.year_hi, set_q.weekday};
				pfer_pkg::PFER_OFS_SET_LOAD: rd_val = 32'h0000_0000;
				default:                     rd_ok  = 1'b0;
			endcase
		end
	end

	// Read data channel
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= pfer_pkg::PFER_RESP_OKAY;
		end
		else if (clk_en)
		begin
			if (s_axi_arvalid && s_axi_arready)
			begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata  <= rd_val;
				s_axi_rresp  <= rd_ok ? pfer_pkg::PFER_RESP_OKAY : pfer_pkg::PFER_RESP_SLVERR;
			end
			else if (s_axi_rready)
				s_axi_rvalid <= 1'b0;
		end
	end

	// Checks
	in_overlay_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && input_refresh |=> input_image == $past(fin_over))
		else $error("input image not overlaid");
	out_overlay_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && output_refresh && !all_outputs_off_instruction |=> out_pins == $past(fout_over))
		else $error("output overlay wrong");
	all_outputs_off_instruction_prio_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && all_outputs_off_instruction |=> out_pins == 16'h0000)
		else $error("outputs not off");
	force_keep_a: assert property (@(posedge aclk) disable iff (!cold_resetn)
		!aresetn && !wr_go |=> $stable(fin_en_q) && $stable(fout_val_q))
		else $error("force settings lost on reset");
	log_wrap_a: assert property (@(posedge aclk) disable iff (!cold_resetn)
		clk_en && error_halt |=> log_pos_q == (($past(log_pos_q) == pfer_pkg::PFER_LOG_ENTRIES) ? 5'h01
			: $past(log_pos_q) + 5'h01))
		else $error("log position not advanced");
	log_code_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && error_halt |=> log_mem[{$past(log_slot), 2'b11}] == $past(error_code))
		else $error("error code not logged");
	clock_copy_a: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en && scan_start |=> clk_words_q == $past(live_words))
		else $error("clock words not refreshed");
	rtc_fault_a: assert property (@(posedge aclk) disable iff (!cold_resetn)
		set_load && !time_ok(set_q) |=> rtc_state_q == pfer_pkg::PFER_RTC_FAULT ##1 $stable(time_q) || $past(set_load))
		else $error("bad time did not stop clock");
	rtc_resume_a: assert property (@(posedge aclk) disable iff (!cold_resetn)
		set_load && time_ok(set_q) |=> rtc_running && time_q == $past(set_q))
		else $error("clock did not resume");

endmodule // pfer_top

// *** test/pfer_field_model.sv ***
`timescale 1ns/100ps
// Far side: input terminals and the backup 1 Hz oscillator
module pfer_field_model (
	// Clock and bench requests
	input  wire logic        aclk,
	input  wire logic [15:0] pins_set,
	input  wire logic        tick_go,
	// Terminals
	output logic [15:0]      in_pins,
	output logic             sec_tick
);
	logic [2:0] tick_q = 3'h0;
	// Terminal levels; tick held long enough to pass the sync
	always_ff @(posedge aclk)
	begin
		in_pins <= pins_set;
		tick_q  <= tick_go ? 3'h4 : tick_q - {2'h0, |tick_q};
	end
	assign sec_tick = |tick_q;
endmodule // pfer_field_model

// *** test/testbench.sv ***
`timescale 1ns/100ps
module testbench;
	logic        aclk, aresetn, cold_resetn, awvalid, wvalid, bready, arvalid, rready;
	logic        in_ref, out_ref, scan, off, err, tick_go, dri, dro;
	logic [11:0] awaddr, araddr;
	logic [31:0] wdata;
	logic [15:0] oimg, ecode, pins, dmask;
	wire logic   awready, wready, bvalid, arready, rvalid, running, sec_tick;
	wire logic [31:0] rdata;
	wire logic [15:0] iimg, opins, in_pins;
	wire logic [1:0]  bresp, rresp;
	int          error_cnt = 0, checks_done = 0, cyc = 0;

	pfer_top i_pfer_top (.aclk(aclk), .aresetn(aresetn), .cold_resetn(cold_resetn), .clk_en(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .input_refresh(in_ref), .output_refresh(out_ref), .scan_start(scan),
		.direct_refresh_in(dri), .direct_refresh_out(dro), .direct_refresh_mask(dmask),
		.all_outputs_off_instruction(off), .output_image(oimg), .error_halt(err), .error_code(ecode),
		.input_image(iimg), .in_pins(in_pins), .sec_tick(sec_tick), .out_pins(opins), .rtc_running(running));
	pfer_field_model i_pfer_field_model (.aclk(aclk), .pins_set(pins), .tick_go(tick_go),
		.in_pins(in_pins), .sec_tick(sec_tick));

	// Clock and hang guard
	initial
	begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			error_cnt++;
			stop_test();
		end
	end

	task automatic stop_test();
		$display("checks %0d errors %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask

	// Register write: both channels offered together
	task automatic wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] er = 2'b00);
		logic ta, tw, b;
		logic [1:0] br;
		ta = 1'b0;
		tw = 1'b0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= {16'h0000, d};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = ta | (awvalid & awready);
			tw = tw | (wvalid & wready);
			b  = bvalid;
			br = bresp;
			@(posedge aclk);
			if (ta) awvalid <= 1'b0;
			if (tw) wvalid <= 1'b0;
		end while (!b);
		bready <= 1'b0;
		chk("bresp", er, br);
	endtask

	// Register read and compare
	task automatic rd(input logic [11:0] a, input logic [15:0] e, input string n);
		logic t, r;
		logic [31:0] g;
		logic [1:0]  rr;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do
		begin
			@(negedge aclk);
			t = arvalid & arready;
			r = rvalid;
			g = rdata;
			rr = rresp;
			@(posedge aclk);
			if (t) arvalid <= 1'b0;
		end while (!r);
		rready <= 1'b0;
		chk(n, {16'h0000, e}, g);
		chk("rresp", 2'b00, rr);
	endtask

	// One-cycle scan, error or tick strobe
	task automatic st(input int k);
		@(posedge aclk);
		case (k)
			0: in_ref <= 1'b1;
			1: out_ref <= 1'b1;
			2: scan <= 1'b1;
			3: err <= 1'b1;
			5: dri <= 1'b1;
			6: dro <= 1'b1;
			default: tick_go <= 1'b1;
		endcase
		@(posedge aclk);
		{in_ref, out_ref, scan, err, tick_go, dri, dro} <= 7'h00;
		@(negedge aclk);
	endtask

	task automatic force_io();
		wr(12'h010, 16'h0006);
		wr(12'h000, 16'h00ff);
		wr(12'h008, 16'h000f);
		pins <= 16'ha5a5;
		repeat (4) @(posedge aclk);
		st(0);
		chk("input_image", 16'ha5a5, iimg);
		wr(12'h010, 16'h0001);
		st(0);
		chk("input_image", 16'ha50f, iimg);
		wr(12'h004, 16'h000f);
		wr(12'h00c, 16'h0005);
		oimg <= 16'h00f0;
		st(1);
		chk("out_pins", 16'h00f5, opins);
		off <= 1'b1;
		st(1);
		chk("out_pins", 16'h0000, opins);
		off   <= 1'b0;
		pins  <= 16'h0f0f;
		dmask <= 16'hf000;
		repeat (4) @(posedge aclk);
		st(5);
		chk("input_image", 16'h050f, iimg);
		dmask <= 16'h00f0;
		st(6);
		chk("out_pins", 16'h00f0, opins);
		@(posedge aclk) aresetn <= 1'b0;
		@(posedge aclk) aresetn <= 1'b1;
		rd(12'h000, 16'h00ff, "in_enable");
		rd(12'h00c, 16'h0005, "out_value");
	endtask

	task automatic clock_and_log();
		wr(12'h030, 16'h0207);
		wr(12'h034, 16'h2313);
		wr(12'h038, 16'h5959);
		wr(12'h03c, 16'h2002);
		wr(12'h040, 16'h0001);
		chk("running", 1'b1, running);
		st(4);
		repeat (8) @(posedge aclk);
		st(2);
		rd(12'h01c, 16'h2314, "day_hour");
		rd(12'h020, 16'h0000, "min_sec");
		rd(12'h024, 16'h2002, "year_hi_wday");
		ecode <= 16'h0042;
		st(3);
		wr(12'h014, 16'h0005, 2'b10);
		rd(12'h014, 16'h0001, "log_pos");
		rd(12'h104, 16'h2314, "log_day_hour");
		rd(12'h10c, 16'h0042, "log_code");
		ecode <= 16'h0077;
		repeat (16) st(3);
		rd(12'h014, 16'h0001, "log_pos");
		rd(12'h10c, 16'h0077, "log_code");
		wr(12'h030, 16'h0214);
		wr(12'h040, 16'h0001);
		chk("running", 1'b0, running);
	endtask

	// Main sequence
	initial
	begin
		{aresetn, cold_resetn, awvalid, wvalid, bready, arvalid, rready} = 7'h00;
		{in_ref, out_ref, scan, off, err, tick_go, dri, dro} = 8'h00;
		{awaddr, araddr, wdata, oimg, ecode, pins, dmask} = 120'h0;
		repeat (6) @(posedge aclk);
		aresetn     <= 1'b1;
		cold_resetn <= 1'b1;
		force_io();
		clock_and_log();
		stop_test();
	end
endmodule // testbench
